// *** include/bdpm_params.svh ***
// bdpm_params.svh: offsets, field positions, reset values and counts of the
// diagnostic and power-management capability register bank.
// assumes: included by bare name into the package and the design modules.
`ifndef BDPM_PARAMS_SVH
`define BDPM_PARAMS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define BDPM_IDX_DIAG        8'h93
`define BDPM_IDX_CAP_ID      8'hA0
`define BDPM_IDX_NEXT_PTR    8'hA1
`define BDPM_IDX_PM_CAP      8'hA2
`define BDPM_FUNC_SEL_BIT    10
`define BDPM_ADDR_W          12

// ****************************************************************
// diagnostic register fields and reset
// ****************************************************************
`define BDPM_DIAG_RESET      8'h60
`define BDPM_DIAG_ID_MASK    7
`define BDPM_DIAG_FIXED_ONE  6
`define BDPM_DIAG_ROUTE      5
`define BDPM_DIAG_DLY_DIS    4
`define BDPM_DIAG_LONG_RETRY_LIMIT  3
`define BDPM_DIAG_CARD_DISC  2
`define BDPM_DIAG_HOST_DISC  1
`define BDPM_DIAG_RESERVED_FIELD       0
`define BDPM_DIAG_GLOBAL_MSK 8'h9E
`define BDPM_DIAG_LOCAL_MSK  8'h21

// ****************************************************************
// capability registers
// ****************************************************************
`define BDPM_CAP_ID_VAL      8'h01
`define BDPM_NEXT_PTR_VAL    8'h00
`define BDPM_PM_CAP_RESET    16'hFE12
`define BDPM_PM_CAP_FIXED    16'h7E12
`define BDPM_PM_CAP_D3C      15

// ****************************************************************
// timing counts
// ****************************************************************
`define BDPM_RETRY_SHORT     7'h10
`define BDPM_RETRY_LONG      7'h40
`define BDPM_DISC_SHORT_EXP  10
`define BDPM_DISC_LONG_EXP   15
`define BDPM_ID_ALL_ONES     16'hFFFF

`endif

// *** include/bdpm_pkg.sv ***
// bdpm_pkg: types shared by the register bank and its helpers.
// assumes: bdpm_params.svh on the include path.
`include "bdpm_params.svh"

package bdpm_pkg;

    // ****************************************************************
    // register decode result
    // ****************************************************************
    typedef enum logic [2:0] {
        BDPM_SEL_NONE   = 3'b000,
        BDPM_SEL_DIAG   = 3'b001,
        BDPM_SEL_CAP_ID = 3'b010,
        BDPM_SEL_NEXT   = 3'b011,
        BDPM_SEL_PM_CAP = 3'b100
    } bdpm_reg_sel_t;

    typedef logic [7:0]  bdpm_diag_t;
    typedef logic [15:0] bdpm_pm_cap_t;

endpackage : bdpm_pkg

// *** design/bdpm_discard_timer.sv ***
// bdpm_discard_timer: counts while a transaction waits and pulses on expiry.
// assumes: pending is held for the whole wait and dropped when it completes.
`include "bdpm_params.svh"

module bdpm_discard_timer
    import bdpm_pkg::*;
#(
    parameter int SHORT_LEN = 1 << `BDPM_DISC_SHORT_EXP,
    parameter int LONG_LEN  = 1 << `BDPM_DISC_LONG_EXP
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic pending,
    input  wire logic short_sel,
    output logic      expired
);
    logic [16:0] count_q;
    logic [16:0] limit;

    // the length is chosen live, so a select change mid-wait takes effect at once
    assign limit = short_sel ? 17'(SHORT_LEN - 1) : 17'(LONG_LEN - 1);

    // ****************************************************************
    // counter
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset || !pending) begin
            count_q <= 17'h00000;
        end else if (count_q != limit) begin
            count_q <= count_q + 17'h00001;
        end
    end

    // expiry flag registered so the output comes from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            expired <= 1'b0;
        end else begin
            expired <= pending && (count_q == limit) && !expired;
        end
    end

    chk_expiry_moment : assert property (@(posedge clk) disable iff (reset)
        expired |-> $past(pending) && $past(count_q) == $past(limit))
        else $error("discard expiry without full count");

endmodule : bdpm_discard_timer

// *** design/bdpm_retry_counter.sv ***
// bdpm_retry_counter: counts retries of one request against a retry limit.
// assumes: retry_event is a one-cycle pulse, done ends the request.
`include "bdpm_params.svh"

module bdpm_retry_counter
    import bdpm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [6:0] limit,
    input  wire logic       retry_event,
    input  wire logic       done,
    output logic            limit_hit
);
    logic [6:0] count_q;

    // ****************************************************************
    // retry count, saturating at the limit
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset || done) begin
            count_q <= 7'h00;
        end else if (retry_event && count_q != limit) begin
            count_q <= count_q + 7'h01;
        end
    end

    // stays high until the request ends
    always_ff @(posedge clk) begin
        if (reset || done) begin
            limit_hit <= 1'b0;
        end else if (retry_event && count_q == limit - 7'h01) begin
            limit_hit <= 1'b1;
        end
    end

endmodule : bdpm_retry_counter

// *** design/bdpm_regs.sv ***
// bdpm_regs: diagnostic and power-management capability registers of the
// two-function bridge, reached over APB, with the control they steer.
// assumes: reset is the global reset; host_bus_reset_n is the ordinary bus
// reset; all inputs are synchronous to clk.
//
// Register access over APB is this design's own decision.
`include "bdpm_params.svh"

// Contract
// - diagnostic at 93h, reset value 60h
// - bit 7 set masks ids to ones
// - diagnostic bit 6 reads one always
// - bit 5 selects status-change routing source
// - bit 4 disables delayed transactions
// - bit 3 extends retry limit 16 to 64
// - bit 2 picks card discard length
// - bit 1 picks host discard length
// - sticky bits cleared only by global reset
// - global bits reached through function 0 only
// - capability_identifier at A0h reads 01h
// - next pointer at A1h reads 00h
// - capabilities at A2h reset FE12h
// - bits 15..11 wake states reset to ones
// - bit 15 writable, resets to one
// - bits 14..11 fixed at one
// - bit 10 reads one, D2 supported
// - bit 9 reads one, D1 supported
// - bits 8..6 read zero
// - bit 5 reads zero
// - bits 2..0 read 010b
module bdpm_regs
    import bdpm_pkg::*;
#(
    parameter int SHORT_DISCARD = 1 << `BDPM_DISC_SHORT_EXP,
    parameter int LONG_DISCARD  = 1 << `BDPM_DISC_LONG_EXP
) (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    host_bus_reset_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`BDPM_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [15:0]             true_vendor_id,
    input  wire logic [15:0]             true_device_id,
    output logic      [15:0]             vendor_id_read,
    output logic      [15:0]             device_id_read,
    input  wire logic [1:0]              legacy_route_bit,
    input  wire logic [7:0]              legacy_irq_select,
    input  wire logic [1:0]              status_change_event,
    output logic      [1:0]              status_change_to_host,
    output logic                         deferred_completion_off,
    output logic      [6:0]              long_retry_limit,
    input  wire logic                    retry_event,
    input  wire logic                    request_done,
    output logic                         retry_limit_hit,
    input  wire logic                    card_txn_pending,
    output logic                         card_discard_timer_length,
    output logic                         card_discard_expired,
    input  wire logic                    host_txn_pending,
    output logic                         host_discard_timer_length,
    output logic                         host_discard_expired
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************

    // maps a word address onto the register it names
    function automatic bdpm_reg_sel_t decode_reg(input logic [`BDPM_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'b00 || addr[`BDPM_ADDR_W-1:`BDPM_FUNC_SEL_BIT+1] != '0) begin
            decode_reg = BDPM_SEL_NONE;
        end else begin
            case (idx)
                `BDPM_IDX_DIAG:     decode_reg = BDPM_SEL_DIAG;
                `BDPM_IDX_CAP_ID:   decode_reg = BDPM_SEL_CAP_ID;
                `BDPM_IDX_NEXT_PTR: decode_reg = BDPM_SEL_NEXT;
                `BDPM_IDX_PM_CAP:   decode_reg = BDPM_SEL_PM_CAP;
                default:            decode_reg = BDPM_SEL_NONE;
            endcase
        end
    endfunction : decode_reg

    // diagnostic as seen by one function; globals show only in function 0
    function automatic bdpm_diag_t diag_view(input bdpm_diag_t glob, input bdpm_diag_t loc,
                                             input logic func);
        diag_view = (loc & `BDPM_DIAG_LOCAL_MSK)
                  | (func ? 8'h00 : (glob & `BDPM_DIAG_GLOBAL_MSK))
                  | (8'h01 << `BDPM_DIAG_FIXED_ONE);
    endfunction : diag_view

    // ****************************************************************
    // bus phase decode
    // ****************************************************************
    bdpm_reg_sel_t sel;
    logic          func;
    logic          setup_ph;
    logic          wr_take;
    logic          wr_diag;
    logic          wr_pm_cap;

    assign sel       = decode_reg(paddr);
    assign func      = paddr[`BDPM_FUNC_SEL_BIT];
    assign setup_ph  = psel && !penable;
    // zero wait: the access phase always completes on its first edge
    assign pready    = psel && penable;
    assign wr_take   = pready && pwrite;
    assign wr_diag   = wr_take && (sel == BDPM_SEL_DIAG) && pstrb[0];
    assign wr_pm_cap = wr_take && (sel == BDPM_SEL_PM_CAP) && pstrb[1];

    // ****************************************************************
    // diagnostic register storage
    // ****************************************************************
    bdpm_diag_t   diag_glob_q;
    bdpm_diag_t   diag_loc_q [2];
    logic [1:0]   pm_d3c_q;

    // shared bits, writable only through function 0; global reset only
    always_ff @(posedge clk) begin
        if (reset) begin
            diag_glob_q <= `BDPM_DIAG_RESET & `BDPM_DIAG_GLOBAL_MSK;
        end else if (wr_diag && !func) begin
            diag_glob_q <= pwdata[7:0] & `BDPM_DIAG_GLOBAL_MSK;
        end
    end

    // per-function bits and the writable wake bit; the host bus reset is
    // deliberately not in these processes so they survive it
    genvar gf;
    generate
        for (gf = 0; gf < 2; gf++) begin : g_func
            always_ff @(posedge clk) begin
                if (reset) begin
                    diag_loc_q[gf] <= `BDPM_DIAG_RESET & `BDPM_DIAG_LOCAL_MSK;
                end else if (wr_diag && func == 1'(gf)) begin
                    diag_loc_q[gf] <= pwdata[7:0] & `BDPM_DIAG_LOCAL_MSK;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    pm_d3c_q[gf] <= 1'(`BDPM_PM_CAP_RESET >> `BDPM_PM_CAP_D3C);
                end else if (wr_pm_cap && func == 1'(gf)) begin
                    pm_d3c_q[gf] <= pwdata[`BDPM_PM_CAP_D3C];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // read data and error, captured in the setup phase
    // ****************************************************************
    logic [31:0] rd_word;

    // read-only fields come from constants, so writes can never disturb them
    always_comb begin
        rd_word = 32'h00000000;
        case (sel)
            BDPM_SEL_DIAG:   rd_word[7:0]  = diag_view(diag_glob_q, diag_loc_q[func], func);
            BDPM_SEL_CAP_ID: rd_word[7:0]  = `BDPM_CAP_ID_VAL;
            BDPM_SEL_NEXT:   rd_word[7:0]  = `BDPM_NEXT_PTR_VAL;
            BDPM_SEL_PM_CAP: rd_word[15:0] = `BDPM_PM_CAP_FIXED
                                           | (16'(pm_d3c_q[func]) << `BDPM_PM_CAP_D3C);
            default:         rd_word       = 32'h00000000;
        endcase
    end

    // the host bus reset clears only this transient read path
    always_ff @(posedge clk) begin
        if (reset || !host_bus_reset_n) begin
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h00000000 : rd_word;
        end
    end

    // unmapped addresses answer with an error, reads return zero
    always_ff @(posedge clk) begin
        if (reset) begin
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= (sel == BDPM_SEL_NONE);
        end
    end

    // ****************************************************************
    // steering of the block's own logic
    // ****************************************************************
    logic id_masked;
    assign id_masked = diag_glob_q[`BDPM_DIAG_ID_MASK];

    // identification reads either true or all ones
    always_ff @(posedge clk) begin
        if (reset) begin
            vendor_id_read <= 16'h0000;
            device_id_read <= 16'h0000;
        end else begin
            vendor_id_read <= id_masked ? `BDPM_ID_ALL_ONES : true_vendor_id;
            device_id_read <= id_masked ? `BDPM_ID_ALL_ONES : true_device_id;
        end
    end

    // status-change routing per function; legacy select field is 4 bits
    genvar gr;
    generate
        for (gr = 0; gr < 2; gr++) begin : g_route
            logic route_ok;
            assign route_ok = diag_loc_q[gr][`BDPM_DIAG_ROUTE]
                            ? (legacy_irq_select[gr*4 +: 4] == 4'h0)
                            : legacy_route_bit[gr];
            always_ff @(posedge clk) begin
                if (reset) begin
                    status_change_to_host[gr] <= 1'b0;
                end else begin
                    status_change_to_host[gr] <= status_change_event[gr] && route_ok;
                end
            end
        end
    endgenerate

    // control levels are registered copies of the stored bits
    always_ff @(posedge clk) begin
        if (reset) begin
            deferred_completion_off   <= 1'b0;
            long_retry_limit          <= `BDPM_RETRY_SHORT;
            card_discard_timer_length <= 1'b0;
            host_discard_timer_length <= 1'b0;
        end else begin
            deferred_completion_off   <= diag_glob_q[`BDPM_DIAG_DLY_DIS];
            long_retry_limit          <= diag_glob_q[`BDPM_DIAG_LONG_RETRY_LIMIT]
                                       ? `BDPM_RETRY_LONG : `BDPM_RETRY_SHORT;
            card_discard_timer_length <= diag_glob_q[`BDPM_DIAG_CARD_DISC];
            host_discard_timer_length <= diag_glob_q[`BDPM_DIAG_HOST_DISC];
        end
    end

    // ****************************************************************
    // helpers: retry count and the two discard timers
    // ****************************************************************
    bdpm_retry_counter u_retry (
        .clk         (clk),
        .reset       (reset),
        .limit       (long_retry_limit),
        .retry_event (retry_event),
        .done        (request_done),
        .limit_hit   (retry_limit_hit)
    );

    // delayed transactions off means no waiting request can age out
    bdpm_discard_timer #(
        .SHORT_LEN (SHORT_DISCARD),
        .LONG_LEN  (LONG_DISCARD)
    ) u_card_disc (
        .clk       (clk),
        .reset     (reset),
        .pending   (card_txn_pending && !deferred_completion_off),
        .short_sel (card_discard_timer_length),
        .expired   (card_discard_expired)
    );

    bdpm_discard_timer #(
        .SHORT_LEN (SHORT_DISCARD),
        .LONG_LEN  (LONG_DISCARD)
    ) u_host_disc (
        .clk       (clk),
        .reset     (reset),
        .pending   (host_txn_pending && !deferred_completion_off),
        .short_sel (host_discard_timer_length),
        .expired   (host_discard_expired)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_read_setup(bdpm_reg_sel_t s);
        setup_ph && !pwrite && sel == s;
    endsequence

    sequence s_read_access;
        pready;
    endsequence

    chk_diag_fixed_one : assert property (
        s_read_setup(BDPM_SEL_DIAG) ##1 s_read_access |-> prdata[6] && prdata[31:8] == 24'h0)
        else $error("diagnostic bit 6 did not read one");

    chk_cap_id_value : assert property (
        s_read_setup(BDPM_SEL_CAP_ID) ##1 s_read_access |-> prdata == 32'h00000001)
        else $error("capability_identifier did not read 01h");

    chk_next_ptr_zero : assert property (
        s_read_setup(BDPM_SEL_NEXT) ##1 s_read_access |-> prdata == 32'h00000000)
        else $error("next pointer not zero");

    chk_pm_cap_fixed : assert property (
        s_read_setup(BDPM_SEL_PM_CAP) ##1 s_read_access
        |-> prdata[14:0] == 15'h7E12 && prdata[31:16] == 16'h0)
        else $error("capabilities fixed fields wrong");

    chk_id_mask_ones : assert property (
        id_masked |=> vendor_id_read == 16'hFFFF && device_id_read == 16'hFFFF)
        else $error("identification not masked");

    chk_func1_global : assert property (
        wr_diag && func |=> $stable(diag_glob_q))
        else $error("function 1 changed a shared bit");

    chk_sticky_hold : assert property (
        !host_bus_reset_n && !wr_diag && !wr_pm_cap
        |=> $stable(diag_glob_q) && $stable(pm_d3c_q))
        else $error("bus reset disturbed sticky bits");

    chk_retry_limit : assert property (
        diag_glob_q[`BDPM_DIAG_LONG_RETRY_LIMIT] ##1 diag_glob_q[`BDPM_DIAG_LONG_RETRY_LIMIT]
        |-> long_retry_limit == 7'h40)
        else $error("retry limit not extended");

    chk_route_select : assert property (
        status_change_event[0] && !diag_loc_q[0][`BDPM_DIAG_ROUTE] && !legacy_route_bit[0]
        |=> !status_change_to_host[0])
        else $error("status change routed while legacy bit clear");

    chk_wake_bit_write : assert property (
        wr_pm_cap && !func |=> pm_d3c_q[0] == $past(pwdata[`BDPM_PM_CAP_D3C]))
        else $error("wake bit write did not land");

    chk_delayed_off : assert property (
        diag_glob_q[`BDPM_DIAG_DLY_DIS] |=> deferred_completion_off)
        else $error("delayed transactions not disabled");

endmodule : bdpm_regs

// *** verification/bdpm_host_model.sv ***
// bdpm_host_model: configuration master on the register bank's apb side.
// assumes: the bench calls xfer; pready may take any number of cycles.
module bdpm_host_model (
    input  logic        clk,
    input  logic        pready,
    input  logic [31:0] prdata,
    input  logic        pslverr,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0]  pstrb
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        {psel, penable, pwrite, pstrb} = '0;
        paddr = '0;
        pwdata = '0;
    end

    // one byte-enabled access: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        input logic [3:0] s, output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd; // stale data must not look valid
    endtask : xfer
endmodule : bdpm_host_model

// *** verification/tb_bridge_diag_and_pm_capability_regs.sv ***
// tb_bridge_diag_and_pm_capability_regs: register reads, writes and steering.
// assumes: zero-wait apb slave, discard lengths shortened to 4 and 16.
module tb_bridge_diag_and_pm_capability_regs
    import bdpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, reset, hrst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  pstrb;
    logic [15:0] vid, did, vrd, drd;
    logic [1:0]  lrb, ev, to_host;
    logic [7:0]  irq;
    logic [6:0]  lim;
    logic        dco, rty, done, hit, cp, cl, hp, hl, cx, hx;
    int          failures, cmp_count;

    bdpm_host_model host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));

    bdpm_regs #(.SHORT_DISCARD(4), .LONG_DISCARD(16)) uut (.clk(clk), .reset(reset),
        .host_bus_reset_n(hrst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .true_vendor_id(vid), .true_device_id(did),
        .vendor_id_read(vrd), .device_id_read(drd), .legacy_route_bit(lrb),
        .legacy_irq_select(irq), .status_change_event(ev), .status_change_to_host(to_host),
        .deferred_completion_off(dco), .long_retry_limit(lim), .retry_event(rty),
        .request_done(done), .retry_limit_hit(hit), .card_txn_pending(cp),
        .card_discard_timer_length(cl), .card_discard_expired(cx),
        .host_txn_pending(hp), .host_discard_timer_length(hl), .host_discard_expired(hx));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, 4'hF, d, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        host.xfer(1'b0, a, 32'h0, 4'h0, d, e);
        chk(d, x);
    endtask : rd

    // one status-change pulse on function 0, routed result a cycle later
    task automatic pulse_ev(input logic x);
        @(posedge clk) ev <= 2'b01;
        @(posedge clk) ev <= 2'b00;
        #1 chk({31'h0, to_host[0]}, {31'h0, x});
    endtask : pulse_ev

    task automatic report_and_stop;
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // ****************************************************************
    // clock, watchdog, tests
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // a run takes under two hundred cycles; 40000 means a hang
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial begin
        {reset, hrst_n} = 2'b11;
        {irq, lrb, ev, rty, done, cp, hp} = '0;
        vid = 16'h1234;
        did = 16'h5678;
        failures = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(12'h24C, 32'h60);
        rd(12'h64C, 32'h60);
        rd(12'h280, 32'h01);
        rd(12'h284, 32'h00);
        rd(12'h288, 32'hFE12);
        wr(12'h288, 32'h0);
        rd(12'h288, 32'h7E12);
        wr(12'h288, 32'hFFFF_FFFF);
        rd(12'h288, 32'hFE12);
        wr(12'h24C, 32'hFE);
        rd(12'h24C, 32'hFE);
        @(posedge clk);
        #1 chk({vrd, drd}, 32'hFFFF_FFFF);
        chk({31'h0, dco}, 32'h1);
        chk({25'h0, lim}, 32'h40);
        chk({30'h0, cl, hl}, 32'h3);
        wr(12'h64C, 32'hDE);
        rd(12'h64C, 32'h40);
        @(posedge clk) hrst_n <= 1'b0;
        @(posedge clk) hrst_n <= 1'b1;
        rd(12'h24C, 32'hFE);
        host.xfer(1'b0, 12'h000, 32'h0, 4'h0, d, e);
        chk({31'h0, e}, 32'h1);
        wr(12'h24C, 32'h0);
        rd(12'h24C, 32'h40);
        @(posedge clk);
        #1 chk({vrd, drd}, {vid, did});
        chk({25'h0, lim}, 32'h10);
        chk({30'h0, cl, hl}, 32'h0);
        lrb <= 2'b01;
        pulse_ev(1'b1);
        lrb <= 2'b00;
        pulse_ev(1'b0);
        wr(12'h24C, 32'h20);
        pulse_ev(1'b1);
        irq <= 8'h01;
        pulse_ev(1'b0);
        // one retry short of the limit must not flag yet
        repeat (15) begin
            @(posedge clk) rty <= 1'b1;
            @(posedge clk) rty <= 1'b0;
        end
        #1 chk({31'h0, hit}, 32'h0);
        @(posedge clk) rty <= 1'b1;
        @(posedge clk) rty <= 1'b0;
        @(posedge clk) done <= 1'b1;
        #1 chk({31'h0, hit}, 32'h1);
        @(posedge clk) done <= 1'b0;
        #1 chk({31'h0, hit}, 32'h0);
        // both timers on the long length of 16: expiry on the sixteenth edge
        @(posedge clk) {cp, hp} <= 2'b11;
        repeat (15) @(posedge clk);
        #1 chk({30'h0, cx, hx}, 32'h0);
        @(posedge clk);
        #1 chk({30'h0, cx, hx}, 32'h3);
        report_and_stop();
    end
endmodule : tb_bridge_diag_and_pm_capability_regs
